// >>> src/qcfg_pkg.sv
package qcfg_pkg;
  // ****************************************
  // Opcodes
  // ****************************************
  localparam logic [7:0] OP_READ_CFG = 8'h3F;
  localparam logic [7:0] OP_QCFG_B1 = 8'h3D;
  localparam logic [7:0] OP_QCFG_B2 = 8'h2A;
  localparam logic [7:0] OP_QCFG_B3 = 8'h81;
  localparam logic [7:0] OP_QCFG_SET = 8'h66;
  localparam logic [7:0] OP_QCFG_CLR = 8'h67;
  localparam logic [7:0] OP_READ_STATUS = 8'h05;
  localparam logic [7:0] OP_QUAD_READ = 8'h6B;
  localparam logic [7:0] OP_QUAD_WRITE = 8'h44;
  localparam logic [23:0] QCFG_PREFIX = 24'h3D_2A81;
  // ****************************************
  // Configuration and status layout
  // ****************************************
  localparam int QE_BIT = 7;
  localparam logic [7:0] CFG_FIXED = 8'h08;
  localparam logic QE_FACTORY = 1'b0;
  localparam int READY_BIT = 7;
  localparam logic [5:0] QCFG_BITS = 6'd32;
  localparam logic [5:0] BITS_MAX = 6'd63;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int CFG_WRITE_TIME_NS = 15_000_000;
  localparam int CFG_WRITE_CYCLES = CFG_WRITE_TIME_NS / CLK_PERIOD_NS;
  localparam int SCK_HALF_CYCLES = 4;
  localparam int READ_BYTES = 2;
  // ****************************************
  // Host register map
  // ****************************************
  localparam int APB_AW = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STAT = 8'h04;
  localparam logic [1:0] CMD_READ_CFG = 2'h0;
  localparam logic [1:0] CMD_READ_STATUS = 2'h1;
  localparam logic [1:0] CMD_QE_SET = 2'h2;
  localparam logic [1:0] CMD_QE_CLR = 2'h3;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_BYTE_LSB = 8;
endpackage : qcfg_pkg

// >>> src/qcfg_spi_if.sv
`timescale 1ns/1ps
interface qcfg_spi_if;
  logic cs_n;
  logic sck;
  logic si;
  logic so;
  logic so_oe;
  logic wp_n_io2;
  logic rst_n_io3;
  modport dev (input cs_n, input sck, input si, input wp_n_io2, input rst_n_io3, output so, output so_oe);
  modport host (output cs_n, output sck, output si, output wp_n_io2, output rst_n_io3, input so, input so_oe);
endinterface : qcfg_spi_if

// >>> src/qcfg_host.sv
`timescale 1ns/1ps
module qcfg_host #(
  parameter int SCK_HALF = qcfg_pkg::SCK_HALF_CYCLES,
  parameter int RD_BYTES = qcfg_pkg::READ_BYTES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [qcfg_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Control pin levels while quad is off
  input wire logic wp_n_in,
  input wire logic rst_n_in,
  // Link
  qcfg_spi_if.host spi
);
  import qcfg_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_LOW, H_HIGH, H_END} qcfg_hst_t;
  typedef struct packed {
    qcfg_hst_t st;
    logic cs_n;
    logic sck;
    logic wp_n;
    logic rst_n;
    logic [31:0] tx;
    logic [7:0] rx;
    logic [7:0] rx_byte;
    logic [5:0] cnt;
    logic [5:0] total;
    logic [15:0] div;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } qcfg_hreg_t;

  localparam logic [15:0] DIV_LOAD = 16'(SCK_HALF - 1);
  // Fast clocks corrupt the first byte, so RD_BYTES bytes are read and only the last one is kept and reported
  localparam logic [5:0] RD_TOTAL = 6'(8 + 8 * RD_BYTES);

  qcfg_hreg_t q;
  qcfg_hreg_t d;
  logic tick;
  logic setup;
  logic access;
  logic [1:0] cmd;

  function automatic logic [31:0] cmd_frame(input logic [1:0] c);
    case (c)
      CMD_READ_CFG: cmd_frame = {OP_READ_CFG, 24'h00_0000};
      CMD_READ_STATUS: cmd_frame = {OP_READ_STATUS, 24'h00_0000};
      CMD_QE_SET: cmd_frame = {QCFG_PREFIX, OP_QCFG_SET};
      default: cmd_frame = {QCFG_PREFIX, OP_QCFG_CLR};
    endcase
  endfunction : cmd_frame

  always_comb begin
    d = q;
    tick = (q.div == 16'h0000);
    setup = psel && !penable;
    access = psel && penable && q.pready;
    cmd = pwdata[1:0];
    d.wp_n = wp_n_in;
    d.rst_n = rst_n_in;
    // ****************************************
    // APB slave, one wait-free access
    // ****************************************
    if (setup && !q.pready) begin
      d.pready = 1'b1;
      d.pslverr = 1'b0;
      d.prdata = 32'h0000_0000;
      if (paddr == REG_STAT) begin
        d.prdata[STAT_BUSY_BIT] = (q.st != H_IDLE);
        d.prdata[STAT_BYTE_LSB +: 8] = q.rx_byte;
      end else if (paddr != REG_CTRL) begin
        d.pslverr = 1'b1;
      end
    end
    if (access) begin
      d.pready = 1'b0;
      d.pslverr = 1'b0;
    end
    // ****************************************
    // Serial engine
    // ****************************************
    d.div = tick ? DIV_LOAD : q.div - 16'h0001;
    case (q.st)
      H_IDLE: begin
        // Status polling is a plain read-status order; no wait is timed here
        if (access && pwrite && paddr == REG_CTRL) begin
          d.st = H_LOW;
          d.cs_n = 1'b0;
          d.sck = 1'b0;
          d.tx = cmd_frame(cmd);
          d.cnt = 6'd0;
          d.total = cmd[1] ? QCFG_BITS : RD_TOTAL;
          d.div = DIV_LOAD;
        end
      end
      H_LOW: begin
        if (tick) begin
          d.sck = 1'b1;
          d.st = H_HIGH;
        end
      end
      H_HIGH: begin
        if (tick) begin
          d.sck = 1'b0;
          // A released line reads as zero, never as the last driven bit
          d.rx = {q.rx[6:0], spi.so & spi.so_oe};
          d.tx = {q.tx[30:0], 1'b0};
          d.cnt = q.cnt + 6'd1;
          d.st = (q.cnt == q.total - 6'd1) ? H_END : H_LOW;
        end
      end
      H_END: begin
        if (tick) begin
          d.cs_n = 1'b1;
          d.rx_byte = q.rx;
          d.st = H_IDLE;
        end
      end
      default: d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{st: H_IDLE, cs_n: 1'b1, wp_n: 1'b1, rst_n: 1'b1, div: 16'h0000, default: '0};
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign spi.cs_n = q.cs_n;
  assign spi.sck = q.sck;
  assign spi.si = q.tx[31];
  assign spi.wp_n_io2 = q.wp_n;
  assign spi.rst_n_io3 = q.rst_n;
endmodule : qcfg_host

// >>> src/qcfg_device.sv
`timescale 1ns/1ps
module qcfg_device #(
  parameter int WRITE_CYCLES = qcfg_pkg::CFG_WRITE_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  qcfg_spi_if.dev spi,
  // Device state
  output logic quad_io_enable_flag,
  output logic ready,
  // Control pins seen while quad is off
  output logic protect_active,
  output logic hw_reset_req,
  // Quad command accepted
  output logic quad_cmd_pulse,
  output logic [7:0] quad_cmd_opcode
);
  import qcfg_pkg::*;

  typedef enum logic [2:0] {QD_IDLE, QD_RDCFG, QD_RDSTAT, QD_QSEQ, QD_ARMED, QD_IGNORE} qcfg_dst_t;
  typedef struct packed {
    qcfg_dst_t st;
    logic sck_q;
    logic cs_q;
    logic [7:0] sh;
    logic [5:0] cnt;
    logic [2:0] oidx;
    logic so;
    logic so_oe;
    logic busy;
    logic [31:0] tmr;
    logic wr_val;
    logic commit;
    logic qe_o;
    logic ready_o;
    logic prot;
    logic rstreq;
    logic qpulse;
    logic [7:0] qop;
  } qcfg_dreg_t;

  localparam logic [31:0] TMR_LOAD = 32'(WRITE_CYCLES - 1);

  qcfg_dreg_t q;
  qcfg_dreg_t d;
  logic rise;
  logic fall;
  logic [5:0] cnt_n;
  logic [7:0] sh_n;
  logic [7:0] out_byte;
  // Non-volatile cell; deliberately outside presetn so resets never touch it
  logic nv_qe_q = QE_FACTORY;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [7:0] cfg_byte(input logic qe);
    logic [7:0] b;
    b = CFG_FIXED;
    b[QE_BIT] = qe;
    cfg_byte = b;
  endfunction : cfg_byte

  function automatic logic [7:0] exp_byte(input logic [2:0] k);
    case (k)
      3'd2: exp_byte = OP_QCFG_B2;
      3'd3: exp_byte = OP_QCFG_B3;
      default: exp_byte = OP_QCFG_B1;
    endcase
  endfunction : exp_byte

  function automatic logic is_quad_op(input logic [7:0] op);
    is_quad_op = (op == OP_QUAD_READ) || (op == OP_QUAD_WRITE);
  endfunction : is_quad_op

  always_comb begin
    d = q;
    d.commit = 1'b0;
    d.qpulse = 1'b0;
    d.sck_q = spi.sck;
    d.cs_q = spi.cs_n;
    rise = spi.sck && !q.sck_q;
    fall = !spi.sck && q.sck_q;
    cnt_n = (q.cnt == BITS_MAX) ? BITS_MAX : q.cnt + 6'd1;
    sh_n = {q.sh[6:0], spi.si};
    out_byte = 8'h00;
    out_byte[READY_BIT] = !q.busy;
    if (q.st == QD_RDCFG) begin
      out_byte = cfg_byte(nv_qe_q);
    end
    // ****************************************
    // Self-timed programming
    // ****************************************
    // Presetn abandons a write in flight; the cell keeps its old value
    // One wide down-counter instead of a prescaler: simple, at the cost of flops
    if (q.busy) begin
      if (q.tmr == 32'h0000_0000) begin
        d.busy = 1'b0;
        d.commit = 1'b1;
      end else begin
        d.tmr = q.tmr - 32'h0000_0001;
      end
    end
    // ****************************************
    // Command framing
    // ****************************************
    if (spi.cs_n) begin
      // Update starts only on a deselect exactly after the 32nd bit
      if (!q.cs_q && q.st == QD_ARMED && q.cnt == QCFG_BITS && !q.busy) begin
        d.busy = 1'b1;
        d.tmr = TMR_LOAD;
      end
      d.st = QD_IDLE;
      d.cnt = 6'd0;
      d.so_oe = 1'b0;
      // Parked low so no stale bit lingers on the released line
      d.so = 1'b0;
    end else if (rise) begin
      d.sh = sh_n;
      d.cnt = cnt_n;
      if (q.st == QD_ARMED) begin
        d.st = QD_IGNORE;
      end else if (cnt_n[2:0] == 3'd0) begin
        // Opcode decode on byte boundaries only
        case (q.st)
          QD_IDLE: begin
            if (sh_n == OP_READ_CFG && !q.busy) begin
              d.st = QD_RDCFG;
              d.so_oe = 1'b1;
              d.oidx = 3'd7;
            // Status stays readable while programming runs
            end else if (sh_n == OP_READ_STATUS) begin
              d.st = QD_RDSTAT;
              d.so_oe = 1'b1;
              d.oidx = 3'd7;
            end else if (sh_n == OP_QCFG_B1 && !q.busy) begin
              d.st = QD_QSEQ;
            end else begin
              d.st = QD_IGNORE;
              if (is_quad_op(sh_n) && nv_qe_q) begin
                d.qpulse = 1'b1;
                d.qop = sh_n;
              end
            end
          end
          QD_QSEQ: begin
            if (cnt_n == QCFG_BITS) begin
              d.st = QD_ARMED;
              if (sh_n == OP_QCFG_SET) begin
                d.wr_val = 1'b1;
              end else if (sh_n == OP_QCFG_CLR) begin
                d.wr_val = 1'b0;
              end else begin
                d.st = QD_IGNORE;
              end
            end else if (sh_n != exp_byte(cnt_n[5:3])) begin
              d.st = QD_IGNORE;
            end
          end
          default: d.st = q.st;
        endcase
      end
    end else if (fall && (q.st == QD_RDCFG || q.st == QD_RDSTAT)) begin
      // Index wraps so the same byte keeps coming out
      d.so = out_byte[q.oidx];
      d.oidx = q.oidx - 3'd1;
    end
    // ****************************************
    // Pin roles
    // ****************************************
    d.qe_o = nv_qe_q;
    d.ready_o = !d.busy;
    // With quad on, the pins are data lines and lose their control meaning
    // Data patterns on the quad lines can never protect or reset the part
    d.prot = !nv_qe_q && !spi.wp_n_io2;
    d.rstreq = !nv_qe_q && !spi.rst_n_io3;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{st: QD_IDLE, sck_q: 1'b0, cs_q: 1'b1, ready_o: 1'b1, default: '0};
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Non-volatile storage
  // ****************************************
  // Only the flag bit is stored; the other bits are constants
  always_ff @(posedge pclk) begin
    if (q.commit) begin
      nv_qe_q <= q.wr_val;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign spi.so = q.so;
  assign spi.so_oe = q.so_oe;
  assign quad_io_enable_flag = q.qe_o;
  assign ready = q.ready_o;
  assign protect_active = q.prot;
  assign hw_reset_req = q.rstreq;
  assign quad_cmd_pulse = q.qpulse;
  assign quad_cmd_opcode = q.qop;
endmodule : qcfg_device

// >>> verification/qcfg_checker.sv
`timescale 1ns/1ps
module qcfg_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  input wire logic cs_n,
  input wire logic sck,
  input wire logic si,
  input wire logic so,
  input wire logic so_oe
);
  import qcfg_pkg::*;
  // ****************************************
  // Frame tracking
  // ****************************************
  logic sck_q;
  logic [5:0] nb;
  logic [7:0] op;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sck_q <= 1'b0;
      nb <= 6'h00;
      op <= 8'h00;
    end else begin
      sck_q <= sck;
      if (cs_n) begin
        nb <= 6'h00;
      end else if (sck && !sck_q && nb != 6'h3F) begin
        nb <= nb + 6'h01;
      end
      if (!cs_n && sck && !sck_q && nb < 6'h08) begin
        op <= {op[6:0], si};
      end
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_idle3;
    cs_n [*3];
  endsequence
  // Mid high phase: bit count already advanced, output settled
  sequence s_mid_high;
    sck && sck_q && so_oe && !cs_n;
  endsequence
  chk_oe_read_only: assert property (so_oe && nb != 6'h00 |->
    nb >= 6'h08 && (op == OP_READ_CFG || op == OP_READ_STATUS)) else $error("output driven outside a read");
  chk_oe_deselect: assert property (s_idle3 |-> !so_oe) else $error("output not floated");
  chk_so_after_fall: assert property (so_oe && $past(so_oe) && $changed(so) |->
    !sck && !$past(sck)) else $error("output moved while clock high");
  // Enable rises one pclk after the host raises sck, so sck is still high
  chk_oe_start_low: assert property ($rose(so_oe) |-> sck && !cs_n) else $error("bad output start");
  chk_quad_no_out: assert property (nb > 6'h08 && op == OP_QCFG_B1 |-> !so_oe) else $error("quad frame drove");
  chk_oe_hold: assert property (so_oe && !cs_n |=> so_oe || cs_n) else $error("output dropped in frame");
  chk_byte_repeat: assert property (so_oe && !cs_n && op == OP_READ_CFG && nb >= 6'h09 && nb <= 6'h10
    |-> ##64 so == $past(so, 64)) else $error("config byte not repeated");
  chk_cfg_fixed: assert property (s_mid_high ##0 (op == OP_READ_CFG && nb >= 6'h0A && nb[2:0] != 3'h1)
    |-> so == (nb[2:0] == 3'h5)) else $error("reserved bit wrong");
  chk_stat_zero: assert property (s_mid_high ##0 (op == OP_READ_STATUS && nb >= 6'h0A && nb[2:0] != 3'h1)
    |-> !so) else $error("status low bits not zero");
endmodule : qcfg_checker

// >>> verification/qcfg_tb_top.sv
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
  $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module qcfg_tb_top;
  import qcfg_pkg::*;
  // Long enough to read status twice while programming
  localparam int WCYC = 2000;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er, wp_n_in, rst_n_in;
  logic flag, ready, prot, hwrst, qpulse;
  logic [7:0] paddr, qop, b;
  logic [31:0] pwdata, prdata, rd;
  int bad_count, n_tests, cyc;
  qcfg_spi_if qcfg_spi_if_i ();
  qcfg_host qcfg_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .wp_n_in(wp_n_in),
    .rst_n_in(rst_n_in), .spi(qcfg_spi_if_i));
  qcfg_device #(.WRITE_CYCLES(WCYC)) qcfg_device_i (.pclk(pclk), .presetn(presetn), .spi(qcfg_spi_if_i),
    .quad_io_enable_flag(flag), .ready(ready), .protect_active(prot), .hw_reset_req(hwrst),
    .quad_cmd_pulse(qpulse), .quad_cmd_opcode(qop));
  qcfg_checker qcfg_checker_i (.pclk(pclk), .presetn(presetn), .cs_n(qcfg_spi_if_i.cs_n),
    .sck(qcfg_spi_if_i.sck), .si(qcfg_spi_if_i.si), .so(qcfg_spi_if_i.so), .so_oe(qcfg_spi_if_i.so_oe));
  // ****************************************
  // Clock, timeout, verdict
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 40000) begin
      bad_count++;
      give_verdict();
    end
  end
  // ****************************************
  // Access tasks
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic cmd(input logic [1:0] c, output logic [7:0] by);
    apb(1'b1, REG_CTRL, {30'h0, c});
    do begin
      apb(1'b0, REG_STAT, 32'h0000_0000);
    end while (rd[STAT_BUSY_BIT] !== 1'b0);
    by = rd[15:8];
  endtask : cmd
  task automatic pins(input logic exp);
    wp_n_in <= 1'b0;
    rst_n_in <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK("protect", exp, prot)
    `CHK("hw_reset", exp, hwrst)
    wp_n_in <= 1'b1;
    rst_n_in <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask : pins
  task automatic wait_ready;
    do begin
      cmd(CMD_READ_STATUS, b);
    end while (b !== 8'h80);
  endtask : wait_ready
  // ****************************************
  // Tests
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    wp_n_in = 1'b1;
    rst_n_in = 1'b1;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    `CHK("flag", 1'b0, flag)
    `CHK("ready", 1'b1, ready)
    cmd(CMD_READ_CFG, b);
    `CHK("config", CFG_FIXED, b)
    cmd(CMD_READ_STATUS, b);
    `CHK("status", 8'h80, b)
    pins(1'b1);
    $display("test factory state done");
    cmd(CMD_QE_SET, b);
    `CHK("ready", 1'b0, ready)
    cmd(CMD_READ_STATUS, b);
    `CHK("status", 8'h00, b)
    cmd(CMD_READ_CFG, b);
    `CHK("config", 8'h00, b)
    wait_ready();
    `CHK("flag", 1'b1, flag)
    cmd(CMD_READ_CFG, b);
    `CHK("config", 8'h88, b)
    pins(1'b0);
    $display("test quad enable done");
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    `CHK("flag", 1'b1, flag)
    cmd(CMD_READ_CFG, b);
    `CHK("config", 8'h88, b)
    $display("test reset keeps flag done");
    cmd(CMD_QE_CLR, b);
    wait_ready();
    `CHK("flag", 1'b0, flag)
    cmd(CMD_READ_CFG, b);
    `CHK("config", CFG_FIXED, b)
    $display("test quad disable done");
    apb(1'b0, 8'h08, 32'h0000_0000);
    `CHK("slverr", 1'b1, er)
    `CHK("unmapped", 32'h0000_0000, rd)
    apb(1'b0, REG_CTRL, 32'h0000_0000);
    `CHK("ctrl", 32'h0000_0000, rd)
    `CHK("quad_pulse", 1'b0, qpulse)
    `CHK("quad_opcode", 8'h00, qop)
    $display("test register map done");
    give_verdict();
  end
endmodule : qcfg_tb_top
